// >>> hw/seb_params.svh
`ifndef SEB_PARAMS_SVH
`define SEB_PARAMS_SVH
// ==================================================
// Timing figures and derived counts at 100 MHz
// ==================================================
`define SEB_CLK_PERIOD_NS      10
`define SEB_GLITCH_REJECT_NS   100
`define SEB_GLITCH_CYCLES      ((`SEB_GLITCH_REJECT_NS + `SEB_CLK_PERIOD_NS - 1) / `SEB_CLK_PERIOD_NS + 1)
`define SEB_POWERUP_READY_MS   1
`define SEB_POWERUP_CYCLES     (`SEB_POWERUP_READY_MS * 1000000 / `SEB_CLK_PERIOD_NS)
`define SEB_PROGRAM_TIME_MS    5
`define SEB_PROGRAM_CYCLES     (`SEB_PROGRAM_TIME_MS * 1000000 / `SEB_CLK_PERIOD_NS)
// ==================================================
// Address layout
// ==================================================
`define SEB_DEVICE_TYPE        4'hA
`define SEB_BYTE_BITS          4'h8
`define SEB_ACK_SLOT           4'h9
`define SEB_ADDR_BYTES         2'h2
`endif

// >>> hw/seb_pkg.sv
package seb_pkg;
    // Bus engine states, one-hot
    typedef enum logic [5:0] {
        SEB_ST_RESET = 6'h01,
        SEB_ST_IDLE  = 6'h02,
        SEB_ST_ADDR  = 6'h04,
        SEB_ST_RECV  = 6'h08,
        SEB_ST_SEND  = 6'h10,
        SEB_ST_PROG  = 6'h20
    } seb_state_t;
endpackage : seb_pkg

// >>> hw/seb_filter.sv
`timescale 1ns/1ps
`include "seb_params.svh"
// ==================================================
// Two-flop synchroniser plus persistence filter
// ==================================================
module seb_filter #(
    parameter int unsigned CYCLES = `SEB_GLITCH_CYCLES
) (
    input  wire logic clk_in,
    input  wire logic sys_rst_in,
    input  wire logic pin_in,
    output logic      level_out
);
    typedef struct packed {
        logic       s1;     // First sync flop, read only by s2
        logic       s2;     // Second sync flop
        logic [7:0] cnt;    // Cycles the new level has held
        logic       lvl;    // Filtered level
    } seb_flt_t;
    seb_flt_t st_r;
    seb_flt_t st_nxt;
    // Level must persist beyond the reject width; idle lines start high
    always_comb begin
        st_nxt    = st_r;
        st_nxt.s1 = pin_in;
        st_nxt.s2 = st_r.s1;
        if (st_r.s2 == st_r.lvl) begin
            st_nxt.cnt = 8'h00;
        end else if (st_r.cnt >= 8'(CYCLES - 1)) begin
            st_nxt.lvl = st_r.s2;
            st_nxt.cnt = 8'h00;
        end else begin
            st_nxt.cnt = st_r.cnt + 8'h01;
        end
    end
    // Register state
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            st_r <= '{s1: 1'b1, s2: 1'b1, cnt: 8'h00, lvl: 1'b1};
        end else begin
            st_r <= st_nxt;
        end
    end
    assign level_out = st_r.lvl;
endmodule : seb_filter

// >>> hw/seb_slave.sv
`timescale 1ns/1ps
`include "seb_params.svh"
// ==================================================
// Two-wire serial memory slave: bus engine
// ==================================================
// Memory array sits outside; bytes flow through a two-entry buffer with a
// valid/ready pair on write and a next pulse on read. Writes land only at program time.
module seb_slave #(
    parameter int unsigned POWERUP_CYCLES = `SEB_POWERUP_CYCLES,
    parameter int unsigned PROGRAM_CYCLES = `SEB_PROGRAM_CYCLES,
    parameter bit          HAS_WR_INHIBIT = 1'b1
) (
    input  wire logic       clk_in,
    input  wire logic       sys_rst_in,
    input  wire logic       por_in,          // Power-on reset indication, high = reset
    input  wire logic       scl_in,          // Serial clock pin
    input  wire logic       sda_in,          // Serial data pin level
    output logic            sda_out,         // Always low when enabled
    output logic            sda_oe_out,      // High while pulling low
    input  wire logic       chip_select_strap_0,
    input  wire logic       chip_select_strap_1,
    input  wire logic       chip_select_strap_2,
    input  wire logic       wr_inhibit_in,   // Write-inhibit pin
    output logic [7:0]      wr_data_out,     // Received byte (address or data)
    output logic            wr_is_data_out,  // Byte is data, not address
    output logic            wr_valid_out,
    input  wire logic       wr_ready_in,
    output logic            commit_out,      // Pulse: programming cycle begins
    output logic            start_seen_out,  // Pulse: new session header
    input  wire logic [7:0] rd_data_in,      // Byte at current address
    output logic            rd_next_out,     // Pulse: advance read address
    output logic            ready_out        // Device in standby (idle state) only
);
    // ==================================================
    // Input conditioning
    // ==================================================
    logic scl_f;
    logic sda_f;
    logic [2:0] strap_s1_r;                   // First sync stage
    logic [2:0] strap_s2_r;
    logic [1:0] wp_sync_r;
    logic [1:0] por_sync_r;
    seb_filter #(.CYCLES(`SEB_GLITCH_CYCLES)) u_scl_flt (
        .clk_in    (clk_in),
        .sys_rst_in(sys_rst_in),
        .pin_in    (scl_in),
        .level_out (scl_f)
    );
    seb_filter #(.CYCLES(`SEB_GLITCH_CYCLES)) u_sda_flt (
        .clk_in    (clk_in),
        .sys_rst_in(sys_rst_in),
        .pin_in    (sda_in),
        .level_out (sda_f)
    );
    // Straps, inhibit and power-reset flag are pins: two flops each
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            strap_s1_r <= 3'h0;
            strap_s2_r <= 3'h0;
            wp_sync_r  <= 2'h0;
            por_sync_r <= 2'h3;
        end else begin
            strap_s1_r <= {chip_select_strap_2, chip_select_strap_1, chip_select_strap_0};
            strap_s2_r <= strap_s1_r;
            wp_sync_r  <= {wp_sync_r[0], wr_inhibit_in};
            por_sync_r <= {por_sync_r[0], por_in};
        end
    end
    // ==================================================
    // Engine state
    // ==================================================
    typedef struct packed {
        seb_pkg::seb_state_t st;
        logic        scl_d;      // Previous filtered clock
        logic        sda_d;      // Previous filtered data
        logic [3:0]  bit_cnt;    // Clock rises within byte, 0..9
        logic [7:0]  shift;      // Shift register in or out
        logic [1:0]  addr_cnt;   // Memory address bytes received
        logic        ack_slot;   // Cleared on each start, never set or read
        logic        inhibit;    // Write refused this session
        logic        wrote;      // Data byte accepted this session
        logic        sda_oe;
        logic [31:0] timer;      // Power-up or programming count
        logic [7:0]  buf0;       // Two-entry write buffer
        logic [7:0]  buf1;
        logic        tag0;
        logic        tag1;
        logic [1:0]  fill;
        logic        commit;
        logic        start_p;
        logic        rd_next;
        logic        rd_nack;    // Master refused last read byte
        logic        valid;      // Buffer holds a word, registered for the port
        logic        idle;       // Standby, registered for the port
    } seb_eng_t;
    seb_eng_t r_r;
    seb_eng_t r_nxt;
    // Chip-select compare; floating straps arrive as zero
    function automatic logic addr_match(input logic [7:0] hdr, input logic [2:0] straps);
        return (hdr[7:4] == `SEB_DEVICE_TYPE) && (hdr[3:1] == straps);
    endfunction : addr_match
    logic rise;
    logic fall;
    logic start_c;
    logic stop_c;
    logic pop;
    logic wp_now;
    always_comb begin
        rise    = scl_f && !r_r.scl_d;
        fall    = !scl_f && r_r.scl_d;
        start_c = scl_f && r_r.scl_d && r_r.sda_d && !sda_f;
        stop_c  = scl_f && r_r.scl_d && !r_r.sda_d && sda_f;
        pop     = (r_r.fill != 2'h0) && wr_ready_in;
        wp_now  = HAS_WR_INHIBIT && wp_sync_r[1];
    end
    // Next-state process
    always_comb begin
        r_nxt         = r_r;
        r_nxt.scl_d   = scl_f;
        r_nxt.sda_d   = sda_f;
        r_nxt.commit  = 1'b0;
        r_nxt.start_p = 1'b0;
        r_nxt.rd_next = 1'b0;
        // Buffer drain shifts entry one down
        if (pop) begin
            r_nxt.buf0 = r_r.buf1;
            r_nxt.tag0 = r_r.tag1;
            r_nxt.fill = r_r.fill - 2'h1;
        end
        case (r_r.st)
            seb_pkg::SEB_ST_RESET: begin
                r_nxt.sda_oe = 1'b0;
                if (r_r.timer >= POWERUP_CYCLES - 1) begin
                    r_nxt.st = seb_pkg::SEB_ST_IDLE;
                end else begin
                    r_nxt.timer = r_r.timer + 32'h1;
                end
            end
            seb_pkg::SEB_ST_PROG: begin
                r_nxt.sda_oe = 1'b0;
                if (r_r.timer >= PROGRAM_CYCLES - 1) begin
                    r_nxt.st = seb_pkg::SEB_ST_IDLE;
                end else begin
                    r_nxt.timer = r_r.timer + 32'h1;
                end
            end
            default: begin
                if (start_c) begin
                    // Any start, repeated or not, opens a header
                    r_nxt.st       = seb_pkg::SEB_ST_ADDR;
                    r_nxt.bit_cnt  = 4'h0;
                    r_nxt.ack_slot = 1'b0;
                    r_nxt.sda_oe   = 1'b0;
                    r_nxt.start_p  = 1'b1;
                    if (r_r.st == seb_pkg::SEB_ST_IDLE) begin
                        r_nxt.addr_cnt = 2'h0;
                        r_nxt.inhibit  = 1'b0;
                        r_nxt.wrote    = 1'b0;
                    end
                end else if (stop_c) begin
                    r_nxt.sda_oe = 1'b0;
                    // Consumed here so a stray stop in standby cannot program twice
                    r_nxt.wrote  = 1'b0;
                    if (r_r.wrote && !r_r.inhibit) begin
                        r_nxt.st     = seb_pkg::SEB_ST_PROG;
                        r_nxt.timer  = 32'h0;
                        r_nxt.commit = 1'b1;
                    end else begin
                        r_nxt.st = seb_pkg::SEB_ST_IDLE;
                    end
                end else if (r_r.st != seb_pkg::SEB_ST_IDLE) begin
                    if (rise) begin
                        r_nxt.bit_cnt = r_r.bit_cnt + 4'h1;
                        if (r_r.bit_cnt < `SEB_BYTE_BITS) begin
                            r_nxt.shift = {r_r.shift[6:0], sda_f};
                        end
                        if (r_r.st == seb_pkg::SEB_ST_SEND && r_r.bit_cnt == `SEB_BYTE_BITS) begin
                            r_nxt.rd_nack = sda_f;
                        end
                    end else if (fall && r_r.bit_cnt == `SEB_BYTE_BITS) begin
                        // Acknowledge slot opens on this fall
                        r_nxt.sda_oe = 1'b0;
                        if (r_r.st == seb_pkg::SEB_ST_ADDR) begin
                            if (addr_match(r_r.shift, strap_s2_r)) begin
                                r_nxt.sda_oe = 1'b1;
                            end else begin
                                r_nxt.st = seb_pkg::SEB_ST_IDLE;
                            end
                        end else if (r_r.st == seb_pkg::SEB_ST_RECV) begin
                            if (r_r.addr_cnt < `SEB_ADDR_BYTES) begin
                                r_nxt.sda_oe   = r_r.fill != 2'h2;
                                r_nxt.addr_cnt = r_r.addr_cnt + 2'h1;
                            end else begin
                                r_nxt.sda_oe = !r_r.inhibit && r_r.fill != 2'h2;
                                r_nxt.wrote  = r_r.wrote | (!r_r.inhibit && r_r.fill != 2'h2);
                            end
                            if (r_nxt.sda_oe) begin
                                // Enqueue accepted byte
                                if (r_nxt.fill == 2'h0) begin
                                    r_nxt.buf0 = r_r.shift;
                                    r_nxt.tag0 = r_r.addr_cnt == `SEB_ADDR_BYTES;
                                end else begin
                                    r_nxt.buf1 = r_r.shift;
                                    r_nxt.tag1 = r_r.addr_cnt == `SEB_ADDR_BYTES;
                                end
                                r_nxt.fill = r_nxt.fill + 2'h1;
                            end
                        end
                    end else if (fall && r_r.bit_cnt == `SEB_ACK_SLOT) begin
                        // Byte boundary: pick direction and load data
                        r_nxt.bit_cnt = 4'h0;
                        r_nxt.sda_oe  = 1'b0;
                        if (r_r.st == seb_pkg::SEB_ST_ADDR) begin
                            r_nxt.st = r_r.shift[0] ? seb_pkg::SEB_ST_SEND : seb_pkg::SEB_ST_RECV;
                        end
                        if (r_r.st == seb_pkg::SEB_ST_RECV && r_r.addr_cnt == `SEB_ADDR_BYTES) begin
                            r_nxt.inhibit = r_r.inhibit | wp_now;
                        end
                        if (r_nxt.st == seb_pkg::SEB_ST_SEND) begin
                            if (r_r.st == seb_pkg::SEB_ST_SEND && r_r.rd_nack) begin
                                r_nxt.st = seb_pkg::SEB_ST_IDLE;
                            end else begin
                                r_nxt.shift   = rd_data_in;
                                r_nxt.rd_next = 1'b1;
                                r_nxt.sda_oe  = !rd_data_in[7];
                            end
                        end
                    end else if (fall && r_r.st == seb_pkg::SEB_ST_SEND && r_r.bit_cnt < `SEB_BYTE_BITS) begin
                        r_nxt.sda_oe = !r_r.shift[7];
                    end
                end
            end
        endcase
        // Reasserted power reset wins over state, timer and data-line drive
        if (por_sync_r[1]) begin
            r_nxt.st     = seb_pkg::SEB_ST_RESET;
            r_nxt.timer  = 32'h0;
            r_nxt.sda_oe = 1'b0;
        end
        // Flags leave straight from flops; same timing as decoding r_r
        r_nxt.valid = r_nxt.fill != 2'h0;
        r_nxt.idle  = r_nxt.st == seb_pkg::SEB_ST_IDLE;
    end
    // Register state
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            r_r       <= '0;
            r_r.st    <= seb_pkg::SEB_ST_RESET;
            r_r.scl_d <= 1'b1;
            r_r.sda_d <= 1'b1;
        end else begin
            r_r <= r_nxt;
        end
    end
    // Outputs straight from flops; data line only ever pulled low
    assign sda_out        = 1'b0;
    assign sda_oe_out     = r_r.sda_oe;
    assign wr_data_out    = r_r.buf0;
    assign wr_is_data_out = r_r.tag0;
    assign wr_valid_out   = r_r.valid;
    assign commit_out     = r_r.commit;
    assign start_seen_out = r_r.start_p;
    assign rd_next_out    = r_r.rd_next;
    assign ready_out      = r_r.idle;
endmodule : seb_slave

// >>> test/seb_slave_sva.sv
`timescale 1ns/1ps
// ==================================================
// Port checks for the bus slave
// ==================================================
module seb_slave_sva #(
    parameter int unsigned POWERUP_CYCLES = 50,
    parameter int unsigned PROGRAM_CYCLES = 200
) (
    input wire logic       clk_in,
    input wire logic       sys_rst_in,
    input wire logic       por_in,
    input wire logic       scl_in,
    input wire logic       sda_out,
    input wire logic       sda_oe_out,
    input wire logic [7:0] wr_data_out,
    input wire logic       wr_valid_out,
    input wire logic       wr_ready_in,
    input wire logic       commit_out,
    input wire logic       ready_out
);
    // Margins cover the sync flops ahead of the counters
    localparam int PU_MAX = POWERUP_CYCLES + 10;
    localparam int PG_MAX = PROGRAM_CYCLES + 10;
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (sys_rst_in);
    property p_od; sda_oe_out |-> !sda_out; endproperty
    a_od: assert property (p_od) else $error("data line driven high");
    property p_rst; $fell(sys_rst_in) |-> !ready_out && !sda_oe_out && !wr_valid_out; endproperty
    a_rst: assert property (p_rst) else $error("outputs busy after reset");
    property p_por; por_in [*5] |=> !ready_out; endproperty
    a_por: assert property (p_por) else $error("ready while power reset held");
    property p_pu; ($fell(sys_rst_in) || $fell(por_in)) && !por_in |-> ##[1:PU_MAX] ready_out; endproperty
    a_pu: assert property (p_pu) else $error("not ready in time");
    property p_edge; $changed(sda_oe_out) |-> !scl_in; endproperty
    a_edge: assert property (p_edge) else $error("data changed with clock high");
    property p_prog; commit_out |=> (!ready_out && !sda_oe_out) [*8]; endproperty
    a_prog: assert property (p_prog) else $error("active during programming");
    property p_prog_end; commit_out |-> ##[1:PG_MAX] ready_out; endproperty
    a_prog_end: assert property (p_prog_end) else $error("programming overran");
    property p_quiet; ready_out |-> !sda_oe_out; endproperty
    a_quiet: assert property (p_quiet) else $error("line pulled in standby");
    property p_hold; wr_valid_out && !wr_ready_in |=> wr_valid_out && $stable(wr_data_out); endproperty
    a_hold: assert property (p_hold) else $error("stalled word lost");
    // Main scenarios reached
    c_commit: cover property (commit_out);
    c_stall: cover property (wr_valid_out && !wr_ready_in);
    c_ack: cover property ($rose(sda_oe_out));
endmodule : seb_slave_sva

bind seb_slave seb_slave_sva #(.POWERUP_CYCLES(POWERUP_CYCLES), .PROGRAM_CYCLES(PROGRAM_CYCLES)) sva_u (
    .clk_in(clk_in), .sys_rst_in(sys_rst_in), .por_in(por_in), .scl_in(scl_in),
    .sda_out(sda_out), .sda_oe_out(sda_oe_out), .wr_data_out(wr_data_out),
    .wr_valid_out(wr_valid_out), .wr_ready_in(wr_ready_in), .commit_out(commit_out),
    .ready_out(ready_out));

// >>> test/seb_master_model.sv
`timescale 1ns/1ps
// ==================================================
// Two-wire master, clock stands high between frames
// ==================================================
module seb_master_model (
    output logic      scl_out,    // Bus clock pin
    output logic      sda_oe_out, // High while pulling data low
    input  wire logic sda_in      // Resolved data line
);
    localparam int TICK = 125;    // Link step; phases are 4 steps
    initial begin
        scl_out = 1'b1;
        sda_oe_out = 1'b0;
    end
    // One bit; entered with clock just fallen
    task automatic bit_xfer(input logic b, output logic s);
        #TICK sda_oe_out = !b;         // Data moves only while clock low
        #(3 * TICK) scl_out = 1'b1;
        #(2 * TICK) s = sda_in;
        #(2 * TICK) scl_out = 1'b0;
    endtask : bit_xfer
    // Start or repeated start
    task automatic bus_start();
        #TICK sda_oe_out = 1'b0;
        #TICK scl_out = 1'b1;
        #(4 * TICK) sda_oe_out = 1'b1;
        #(4 * TICK) scl_out = 1'b0;
    endtask : bus_start
    // Stop, then idle gap before anything else
    task automatic bus_stop();
        #TICK sda_oe_out = 1'b1;
        #(3 * TICK) scl_out = 1'b1;
        #(4 * TICK) sda_oe_out = 1'b0;
        #(5 * TICK);
    endtask : bus_stop
    // Byte out MSB first, acknowledge back
    task automatic byte_tx(input logic [7:0] d, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_xfer(d[i], s);
        end
        bit_xfer(1'b1, s);
        ack = !s;
    endtask : byte_tx
    // Byte in; master acknowledge asks for more
    task automatic byte_rx(input logic more, output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_xfer(1'b1, d[i]);
        end
        bit_xfer(!more, s);
    endtask : byte_rx
    // Short low pulse on idle data line
    task automatic glitch();
        sda_oe_out = 1'b1;
        #90 sda_oe_out = 1'b0;
    endtask : glitch
endmodule : seb_master_model

// >>> test/seb_slave_tb_top.sv
`timescale 1ns/1ps
// ==================================================
// Bench: two slaves on one bus with a master model
// ==================================================
module seb_slave_tb_top;
    logic       clk_in = 1'b0;
    logic       sys_rst_in = 1'b1;
    logic       por_in = 1'b0;
    logic [2:0] strap = 3'h5;     // Straps of main slave
    logic [2:0] strap_b = 3'h7;   // Straps of slave without inhibit pin
    logic       inh = 1'b0;       // Write-inhibit pin
    logic       wr_ready = 1'b1;  // Consumer ready
    logic [7:0] rd_data = 8'hC3;  // Read byte, steps on each advance
    logic       m_scl, m_oe, oe_a, oe_b, sda_a;
    logic       wr_valid, wr_is_data, commit, start_seen, rd_next, ready;
    logic [7:0] wr_data;
    logic [8:0] q [$];            // Drained write entries
    int         fail_count = 0, checked = 0, commits = 0, starts = 0, cyc = 0;
    wire        sda = !(m_oe || oe_a || oe_b); // Pulled up unless pulled low
    always #5 clk_in = !clk_in;
    seb_master_model m_u (.scl_out(m_scl), .sda_oe_out(m_oe), .sda_in(sda));
    seb_slave #(.POWERUP_CYCLES(50), .PROGRAM_CYCLES(200)) dut_u (
        .clk_in(clk_in), .sys_rst_in(sys_rst_in), .por_in(por_in), .scl_in(m_scl), .sda_in(sda),
        .sda_out(sda_a), .sda_oe_out(oe_a), .chip_select_strap_0(strap[0]),
        .chip_select_strap_1(strap[1]), .chip_select_strap_2(strap[2]), .wr_inhibit_in(inh),
        .wr_data_out(wr_data), .wr_is_data_out(wr_is_data), .wr_valid_out(wr_valid),
        .wr_ready_in(wr_ready), .commit_out(commit), .start_seen_out(start_seen),
        .rd_data_in(rd_data), .rd_next_out(rd_next), .ready_out(ready));
    // Variant without inhibit pin, straps all high
    seb_slave #(.POWERUP_CYCLES(50), .PROGRAM_CYCLES(200), .HAS_WR_INHIBIT(1'b0)) dut_nowp_u (
        .clk_in(clk_in), .sys_rst_in(sys_rst_in), .por_in(por_in), .scl_in(m_scl), .sda_in(sda),
        .sda_out(), .sda_oe_out(oe_b), .chip_select_strap_0(strap_b[0]), .chip_select_strap_1(strap_b[1]),
        .chip_select_strap_2(strap_b[2]), .wr_inhibit_in(inh), .wr_data_out(), .wr_is_data_out(),
        .wr_valid_out(), .wr_ready_in(wr_ready), .commit_out(), .start_seen_out(),
        .rd_data_in(rd_data), .rd_next_out(), .ready_out());
    // Consumer, event counters and hang guard
    always @(posedge clk_in) begin
        cyc <= cyc + 1;
        if (wr_valid && wr_ready) q.push_back({wr_is_data, wr_data});
        if (commit) commits <= commits + 1;
        if (start_seen) starts <= starts + 1;
        if (rd_next) rd_data <= rd_data + 8'h11;
        if (cyc == 80000) begin
            fail_count++;
            wrap_up();
        end
    end
    task automatic chk_bit(input string n, input logic e, input logic g);
        checked++;
        if (g !== e) begin
            fail_count++;
            $display("ERROR %s expected %b seen %b", n, e, g);
        end
    endtask : chk_bit
    task automatic chk_val(input string n, input logic [8:0] e, input logic [8:0] g);
        checked++;
        if (g !== e) begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask : chk_val
    task automatic cycles(input int n);
        repeat (n) @(posedge clk_in);
    endtask : cycles
    task automatic send(input logic [7:0] d, input logic e, input string n);
        logic a;
        m_u.byte_tx(d, a);
        chk_bit(n, e, a);
    endtask : send
    task automatic send_h(input logic [7:0] h, input logic e, input string n);
        m_u.bus_start();
        send(h, e, n);
    endtask : send_h
    task automatic t_power();
        chk_bit("ready_early", 1'b0, ready);
        cycles(60);
        chk_bit("ready_late", 1'b1, ready);
    endtask : t_power
    task automatic t_addr();
        logic [2:0] s [4] = '{3'h5, 3'h5, 3'h5, 3'h0};
        logic [7:0] h [4] = '{8'hAA, 8'hA6, 8'h2A, 8'hA0};
        logic       e [4] = '{1'b1, 1'b0, 1'b0, 1'b1};
        for (int i = 0; i < 4; i++) begin
            @(posedge clk_in) strap <= s[i];
            cycles(5);
            send_h(h[i], e[i], "addr_ack");
            m_u.bus_stop();
        end
        @(posedge clk_in) strap <= 3'h5;
        cycles(5);
    endtask : t_addr
    task automatic t_write();
        logic [8:0] ex [6] = '{9'h012, 9'h034, 9'h012, 9'h034, 9'h15A, 9'h1A5};
        int c0;
        @(posedge clk_in) wr_ready <= 1'b0;
        q.delete();
        send_h(8'hAA, 1'b1, "stall_hdr");
        send(8'h12, 1'b1, "stall_b0");
        send(8'h34, 1'b1, "stall_b1");
        send(8'h5A, 1'b0, "full_refuse"); // Buffer full, byte refused
        m_u.bus_stop();
        @(posedge clk_in) wr_ready <= 1'b1;
        c0 = commits;
        send_h(8'hAA, 1'b1, "wr_hdr");
        for (int i = 2; i < 6; i++) begin
            send(ex[i][7:0], 1'b1, "wr_byte");
        end
        m_u.bus_stop();
        chk_val("commit", 9'(c0 + 1), 9'(commits));
        send_h(8'hAA, 1'b0, "busy_refuse");
        m_u.bus_stop();
        cycles(250);
        send_h(8'hAA, 1'b1, "after_prog");
        m_u.bus_stop();
        chk_val("no_recommit", 9'(c0 + 1), 9'(commits));
        chk_val("entries", 9'h006, 9'(q.size()));
        for (int i = 0; i < 6; i++) begin
            chk_val("wr_entry", ex[i], q[i]);
        end
    endtask : t_write
    task automatic t_inhibit();
        int c0;
        @(posedge clk_in) inh <= 1'b1;
        cycles(5);
        c0 = commits;
        send_h(8'hAA, 1'b1, "wp_hdr");
        send(8'h00, 1'b1, "wp_addr");
        send(8'h10, 1'b1, "wp_addr");
        send(8'h77, 1'b0, "wp_data");
        m_u.bus_stop();
        chk_val("wp_commit", 9'(c0), 9'(commits));
        send_h(8'hAE, 1'b1, "nowp_hdr");
        send(8'h00, 1'b1, "nowp_addr");
        send(8'h10, 1'b1, "nowp_addr");
        send(8'h77, 1'b1, "nowp_data");
        m_u.bus_stop();
        @(posedge clk_in) inh <= 1'b0;
    endtask : t_inhibit
    task automatic t_read();
        logic [7:0] d;
        send_h(8'hAB, 1'b1, "rd_hdr");
        m_u.byte_rx(1'b1, d);
        chk_val("rd_byte0", 9'h0C3, {1'b0, d});
        m_u.byte_rx(1'b0, d);
        chk_val("rd_byte1", 9'h0D4, {1'b0, d});
        m_u.bus_stop();
    endtask : t_read
    task automatic t_glitch();
        int s0;
        s0 = starts;
        m_u.glitch();
        cycles(40);
        chk_val("glitch_start", 9'(s0), 9'(starts));
        m_u.bus_start();
        m_u.bus_stop();
        chk_val("real_start", 9'(s0 + 1), 9'(starts));
    endtask : t_glitch
    task automatic t_por();
        @(posedge clk_in) por_in <= 1'b1;
        cycles(10);
        chk_bit("ready_por", 1'b0, ready);
        @(posedge clk_in) por_in <= 1'b0;
        cycles(70);
        chk_bit("ready_after_por", 1'b1, ready);
        send_h(8'hAA, 1'b1, "por_hdr");
        m_u.bus_stop();
    endtask : t_por
    task automatic wrap_up();
        $display("checked %0d fail_count %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : wrap_up
    // Main sequence
    initial begin
        cycles(3);
        sys_rst_in <= 1'b0;
        @(posedge clk_in);
        t_power();
        t_addr();
        t_write();
        t_inhibit();
        t_read();
        t_glitch();
        t_por();
        wrap_up();
    end
endmodule : seb_slave_tb_top
